/* File: cas_conv_model.sv */
// Converter model: logs each unmuted start and answers two cycles later
`timescale 1ns/1ps
module cas_conv_model (
  // Clock
  input wire logic clk_in,
  // Converter side of the sequencer
  input wire logic conv_start_in,
  input wire logic [3:0] conv_chan_in,
  input wire logic conv_invert_in,
  input wire logic pump_on_in,
  input wire logic balance_open_in,
  // Bench control: ignore starts to provoke the watchdog
  input wire logic mute_in,
  output logic conv_done_out,
  output logic [15:0] conv_data_out
);
  logic [6:0] conv_log [$];
  int recoveries = 0;
  int wait_cnt = 0;
  logic pump_seen = 1'b0;
  logic pump_q = 1'b1;
  initial
  begin
    conv_done_out = 1'b0;
    conv_data_out = 16'h0000;
  end
  task automatic clear;
    conv_log.delete();
    recoveries = 0;
    pump_seen = 1'b0;
  endtask
  // Data toggles outside the done pulse so a stale sample never matches
  always @(posedge clk_in)
  begin
    conv_done_out <= 1'b0;
    conv_data_out <= ~conv_data_out;
    pump_q <= pump_on_in;
    if (pump_on_in && !pump_q)
      pump_seen <= 1'b1;
    if (wait_cnt == 1)
    begin
      conv_done_out <= 1'b1;
      conv_data_out <= {4'h0, conv_chan_in, 8'h40};
    end
    if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    if (conv_start_in && !mute_in)
    begin
      conv_log.push_back({balance_open_in, pump_on_in, conv_invert_in && conv_chan_in < 4'hC,
        conv_chan_in});
      wait_cnt <= 2;
      // A pump pulse between conversions is one recovery period
      if (pump_seen)
        recoveries++;
      pump_seen <= 1'b0;
    end
  end
endmodule

/* File: cas_iir_filter.sv */
// First-order IIR filter datapath, weights in eighths
`timescale 1ns/1ps
module cas_iir_filter (
  // Operands
  input wire logic [15:0] sample_in,
  input wire logic [15:0] prev_in,
  input wire logic [2:0] coef_in,
  // Result
  output logic [15:0] result_out
);
  logic [3:0] new_w;
  logic [3:0] old_w;
  logic [19:0] sum_w;

  // Code c weighs the new sample by (c+1)/8, so the top code passes it straight
  assign new_w = {1'b0, coef_in} + 4'h1;
  assign old_w = 4'h8 - new_w;
  // Worst case is 8 * FFFF, which still fits in 19 bits
  assign sum_w = 20'(sample_in) * 20'(new_w) + 20'(prev_in) * 20'(old_w);
  assign result_out = sum_w[18:3];
endmodule

/* File: cas_pkg.sv */
// Shared constants and types for the cell acquisition sequencer
package cas_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned STEP_US = 96;
  localparam int unsigned STEP_CYC = STEP_US * CLK_MHZ;
  localparam int unsigned RECOVER_NS = 100300;
  localparam int unsigned RECOVER_CYC = RECOVER_NS * CLK_MHZ / 1000;
  // Watchdog limits in units of 10 us
  localparam int unsigned WD_10US_0 = 110;
  localparam int unsigned WD_10US_1 = 208;
  localparam int unsigned WD_10US_2 = 336;
  localparam int unsigned WD_10US_3 = 592;
  localparam int unsigned WD_10US_4 = 1099;
  localparam int unsigned WD_10US_5 = 2118;
  localparam int unsigned WD_10US_6 = 4156;
  localparam int unsigned WD_CYC_0 = WD_10US_0 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_1 = WD_10US_1 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_2 = WD_10US_2 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_3 = WD_10US_3 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_4 = WD_10US_4 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_5 = WD_10US_5 * 10 * CLK_MHZ;
  localparam int unsigned WD_CYC_6 = WD_10US_6 * 10 * CLK_MHZ;
  localparam int unsigned HOP_CYC_DEF = 8;

  // Register offsets
  localparam logic [7:0] ADDR_BAL_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_DEV_CFG = 8'h10;
  localparam logic [7:0] ADDR_MEAS_EN = 8'h12;
  localparam logic [7:0] ADDR_ACQ_CTRL = 8'h13;
  localparam logic [7:0] ADDR_DATA_BASE = 8'h20;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h2C;
  localparam logic [7:0] ADDR_AUX_ONE = 8'h2D;
  localparam logic [7:0] ADDR_AUX_TWO = 8'h2E;
  localparam logic [7:0] ADDR_DIAG = 8'h2F;

  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ORDER_BIT = 1;
  localparam int unsigned CTRL_OS_LSB = 2;
  localparam int unsigned CTRL_FXFER_BIT = 5;
  localparam int unsigned CTRL_FREAD_BIT = 6;
  localparam int unsigned CTRL_DSEL_BIT = 7;
  localparam int unsigned CTRL_BUSY_BIT = 13;
  localparam int unsigned CTRL_TMO_BIT = 14;
  localparam int unsigned CTRL_DONE_BIT = 15;
  localparam int unsigned CFG_COEF_LSB = 0;
  localparam int unsigned CFG_AUTO_OFF_BIT = 11;

  // Values after reset
  localparam logic [2:0] RST_COEF = 3'h2;
  localparam logic [2:0] RST_OS = 3'h0;
  localparam logic [15:0] RST_MEAS_EN = 16'h0FFF;
  localparam logic [15:0] RST_BAL_DELAY = 16'h0000;

  // Conversion slots within one measurement cycle, then the auxiliary slots
  localparam logic [4:0] SLOT_MV1 = 5'h00;
  localparam logic [4:0] SLOT_P1 = 5'h01;
  localparam logic [4:0] SLOT_P2 = 5'h0D;
  localparam logic [4:0] SLOT_MV2 = 5'h19;
  localparam logic [4:0] SLOT_DG1 = 5'h1A;
  localparam logic [4:0] SLOT_END = 5'h1C;
  localparam logic [4:0] SLOT_AUX2 = 5'h1D;
  localparam logic [4:0] SLOT_LAST = 5'h1E;

  // Converter channel codes; also the bit index in the measure enable register
  localparam logic [3:0] CH_MV = 4'hC;
  localparam logic [3:0] CH_AUX1 = 4'hD;
  localparam logic [3:0] CH_AUX2 = 4'hE;
  localparam logic [3:0] CH_DIAG = 4'hF;
  localparam int unsigned NUM_ACC = 13;
  localparam logic [3:0] IDX_LAST = 4'hC;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_HOP = 8'h02,
    ST_BAL_WAIT = 8'h04,
    ST_PUMP_OFF = 8'h08,
    ST_SLOT = 8'h10,
    ST_WAIT = 8'h20,
    ST_RECOVER = 8'h40,
    ST_XFER = 8'h80
  } cas_state_type;

endpackage

/* File: cas_sequencer.sv */
// Cell acquisition sequencer: register port, scan control, averaging and filter transfer
//
// How it works
// - Start bit is a strobe, reads zero
// - Completion flag set after last conversion
// - Start delayed by chain position hops
// - Pump off, then first module voltage
// - First cell pass follows sweep order
// - Second pass descending, then module voltage
// - Two diagnostic conversions when enabled
// - Pump recovery between oversample cycles only
// - Auxiliary inputs last, ascending, before completion
// - Auxiliary inputs converted once only
// - Oversample code selects cycle count
// - Watchdog limit follows oversample code
// - First-order IIR on transferred results
// - Coefficient default 3/8, top code off
// - Filtered transfer bit moves filtered results
// - Read source bit picks filtered or raw
// - Filter covers cells and module voltage
// - Auto-off bit opens balancing switches
// - Balancing wait from selected delay byte
// - Delay spans 96 us to 24.57 ms
// - Watchdog expiry flags, resets, clears cell and module voltage data, keeps auxiliary and diagnostic
// - Order bit: zero pyramid, one top-down
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module cas_sequencer #(
  parameter int unsigned HOP_CYC = cas_pkg::HOP_CYC_DEF,
  parameter int unsigned STEP_CYC = cas_pkg::STEP_CYC,
  parameter int unsigned RECOVER_CYC = cas_pkg::RECOVER_CYC,
  parameter int unsigned WD_CYC [0:7] = '{cas_pkg::WD_CYC_0, cas_pkg::WD_CYC_1,
    cas_pkg::WD_CYC_2, cas_pkg::WD_CYC_3, cas_pkg::WD_CYC_4, cas_pkg::WD_CYC_5,
    cas_pkg::WD_CYC_6, cas_pkg::WD_CYC_6}
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Chain position strap
  input wire logic [4:0] chain_pos_in,
  // Converter
  output logic conv_start_out,
  output logic [3:0] conv_chan_out,
  output logic conv_invert_out,
  input wire logic conv_done_in,
  input wire logic [15:0] conv_data_in,
  // Analog controls and status
  output logic pump_on_out,
  output logic balance_open_out,
  output logic acq_busy_out
);

  function automatic logic [3:0] slot_chan(input logic [4:0] s, input logic topdown);
    logic [3:0] ch;
    ch = cas_pkg::CH_AUX2;
    if (s == cas_pkg::SLOT_MV1 || s == cas_pkg::SLOT_MV2)
      ch = cas_pkg::CH_MV;
    else if (s < cas_pkg::SLOT_P2)
      ch = topdown ? 4'(5'h0C - s) : 4'(s - 5'h01);
    else if (s < cas_pkg::SLOT_MV2)
      ch = 4'(5'h18 - s);
    else if (s < cas_pkg::SLOT_END)
      ch = cas_pkg::CH_DIAG;
    else if (s == cas_pkg::SLOT_END)
      ch = cas_pkg::CH_AUX1;
    return ch;
  endfunction

  function automatic logic [2:0] os_log2(input logic [2:0] code);
    logic [2:0] lg;
    lg = (code == 3'h0) ? 3'h0 : (code >= 3'h6) ? 3'h7 : 3'(code + 3'h1);
    return lg;
  endfunction

  cas_pkg::cas_state_type state_q;
  logic [4:0] pos_s1_q;
  logic [4:0] pos_q;
  logic [2:0] coef_q;
  logic auto_off_q;
  logic [15:0] meas_en_q;
  logic [15:0] bal_delay_q;
  logic order_q;
  logic [2:0] os_q;
  logic fxfer_q;
  logic fread_q;
  logic dsel_q;
  logic done_q;
  logic tmo_q;
  logic [4:0] slot_q;
  logic aux_q;
  logic [7:0] os_cnt_q;
  logic [21:0] cnt_q;
  logic [21:0] wd_q;
  logic [3:0] idx_q;
  logic conv_start_q;
  logic [3:0] conv_chan_q;
  logic conv_invert_q;
  logic pump_on_q;
  logic balance_open_q;
  logic busy_q;
  logic [15:0] rdata_q;
  logic [15:0] raw_q [cas_pkg::NUM_ACC];
  logic [15:0] cell_q [cas_pkg::NUM_ACC];
  logic [23:0] acc_q [cas_pkg::NUM_ACC];
  logic [15:0] aux1_q;
  logic [15:0] aux2_q;
  logic [15:0] diag_q;

  // Register decode
  wire wr_ctrl = reg_wr_in && reg_addr_in == cas_pkg::ADDR_ACQ_CTRL;
  wire wr_cfg = reg_wr_in && reg_addr_in == cas_pkg::ADDR_DEV_CFG;
  wire wr_meas = reg_wr_in && reg_addr_in == cas_pkg::ADDR_MEAS_EN;
  wire wr_delay = reg_wr_in && reg_addr_in == cas_pkg::ADDR_BAL_DELAY;
  wire idle = state_q == cas_pkg::ST_IDLE;
  // A start while a scan runs is ignored rather than restarting it
  wire start_req = wr_ctrl && reg_wdata_in[cas_pkg::CTRL_START_BIT] && idle;

  // Sequencing decode
  wire [3:0] chan_w = slot_chan(slot_q, order_q);
  wire slot_en = meas_en_q[chan_w];
  wire [2:0] os_lg = os_log2(os_q);
  wire [7:0] n_os = 8'(9'h001 << os_lg);
  wire last_os = 8'(os_cnt_q + 8'h01) == n_os;
  wire [21:0] hop_target = 22'(pos_q * HOP_CYC);
  wire [7:0] bal_byte = dsel_q ? bal_delay_q[15:8] : bal_delay_q[7:0];
  wire [21:0] bal_target = 22'((32'(bal_byte) + 32'd1) * STEP_CYC);
  wire [21:0] wd_limit = 22'(WD_CYC[os_q]);
  wire tmo_hit = !idle && wd_q == wd_limit - 22'h000001;
  wire got_conv = state_q == cas_pkg::ST_WAIT && conv_done_in && !tmo_hit;
  wire acc_add = got_conv && conv_chan_q < cas_pkg::CH_AUX1;
  wire xfer_step = state_q == cas_pkg::ST_XFER && !tmo_hit;
  wire xfer_last = xfer_step && idx_q == cas_pkg::IDX_LAST;
  // Each measurement cycle adds two conversions per channel, so the sum carries one extra bit
  // Shift amount widened so the 128-sample code does not wrap to zero
  wire [23:0] avg_full = acc_q[idx_q] >> ({1'b0, os_lg} + 4'h1);
  wire [15:0] avg_w = avg_full[15:0];
  wire [15:0] filt_w;

  // Readback decode
  wire in_data = reg_addr_in >= cas_pkg::ADDR_DATA_BASE && reg_addr_in <= cas_pkg::ADDR_DATA_LAST;
  wire [7:0] data_off = reg_addr_in - cas_pkg::ADDR_DATA_BASE;
  wire [3:0] data_idx = data_off[3:0];
  wire [15:0] data_word = fread_q ? cell_q[data_idx] : raw_q[data_idx];
  wire [15:0] ctrl_word = {done_q, tmo_q, !idle, 5'h00, dsel_q, fread_q, fxfer_q, os_q,
    order_q, 1'b0};
  wire [15:0] cfg_word = {4'h0, auto_off_q, 8'h00, coef_q};
  wire [15:0] read_mux =
    (reg_addr_in == cas_pkg::ADDR_ACQ_CTRL) ? ctrl_word :
    (reg_addr_in == cas_pkg::ADDR_DEV_CFG) ? cfg_word :
    (reg_addr_in == cas_pkg::ADDR_MEAS_EN) ? meas_en_q :
    (reg_addr_in == cas_pkg::ADDR_BAL_DELAY) ? bal_delay_q :
    (reg_addr_in == cas_pkg::ADDR_AUX_ONE) ? aux1_q :
    (reg_addr_in == cas_pkg::ADDR_AUX_TWO) ? aux2_q :
    (reg_addr_in == cas_pkg::ADDR_DIAG) ? diag_q :
    in_data ? data_word : 16'h0000;

  // Flag updates: a hardware set wins over a software clear in the same cycle
  wire done_clr = start_req || (wr_ctrl && reg_wdata_in[cas_pkg::CTRL_DONE_BIT]);
  wire tmo_clr = start_req || (wr_ctrl && reg_wdata_in[cas_pkg::CTRL_TMO_BIT]);

  cas_iir_filter cas_iir_filter_i (
    .sample_in(avg_w),
    .prev_in(cell_q[idx_q]),
    .coef_in(coef_q),
    .result_out(filt_w)
  );

  // Strap synchroniser; only the second stage is used
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      pos_s1_q <= 5'h00;
      pos_q <= 5'h00;
    end
    else
    begin
      pos_s1_q <= chain_pos_in;
      pos_q <= pos_s1_q;
    end

  // Software registers and flags
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      coef_q <= cas_pkg::RST_COEF;
      auto_off_q <= 1'b0;
      meas_en_q <= cas_pkg::RST_MEAS_EN;
      bal_delay_q <= cas_pkg::RST_BAL_DELAY;
      order_q <= 1'b0;
      os_q <= cas_pkg::RST_OS;
      fxfer_q <= 1'b0;
      fread_q <= 1'b0;
      dsel_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      if (wr_cfg)
      begin
        coef_q <= reg_wdata_in[cas_pkg::CFG_COEF_LSB +: 3];
        auto_off_q <= reg_wdata_in[cas_pkg::CFG_AUTO_OFF_BIT];
      end
      if (wr_meas)
        meas_en_q <= reg_wdata_in;
      if (wr_delay)
        bal_delay_q <= reg_wdata_in;
      // Scan setup is frozen while a scan runs so counts stay consistent
      if (wr_ctrl && idle)
      begin
        order_q <= reg_wdata_in[cas_pkg::CTRL_ORDER_BIT];
        os_q <= reg_wdata_in[cas_pkg::CTRL_OS_LSB +: 3];
        fxfer_q <= reg_wdata_in[cas_pkg::CTRL_FXFER_BIT];
        fread_q <= reg_wdata_in[cas_pkg::CTRL_FREAD_BIT];
        dsel_q <= reg_wdata_in[cas_pkg::CTRL_DSEL_BIT];
      end
      done_q <= xfer_last || (done_q && !done_clr);
      tmo_q <= tmo_hit || (tmo_q && !tmo_clr);
      rdata_q <= reg_rd_in ? read_mux : 16'h0000;
    end

  // Watchdog counter
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      wd_q <= 22'h000000;
    else
      wd_q <= (idle || tmo_hit) ? 22'h000000 : wd_q + 22'h000001;

  // Scan state machine
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      state_q <= cas_pkg::ST_IDLE;
      slot_q <= 5'h00;
      aux_q <= 1'b0;
      os_cnt_q <= 8'h00;
      cnt_q <= 22'h000000;
      idx_q <= 4'h0;
      conv_start_q <= 1'b0;
      conv_chan_q <= 4'h0;
      conv_invert_q <= 1'b0;
      pump_on_q <= 1'b1;
      balance_open_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else if (tmo_hit)
    begin
      state_q <= cas_pkg::ST_IDLE;
      conv_start_q <= 1'b0;
      pump_on_q <= 1'b1;
      balance_open_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= 1'b0;
      unique case (state_q)
        cas_pkg::ST_IDLE:
        begin
          balance_open_q <= 1'b0;
          if (start_req)
          begin
            state_q <= cas_pkg::ST_HOP;
            busy_q <= 1'b1;
            cnt_q <= 22'h000000;
            os_cnt_q <= 8'h00;
            aux_q <= 1'b0;
          end
        end
        cas_pkg::ST_HOP:
          if (cnt_q >= hop_target)
          begin
            cnt_q <= 22'h000000;
            balance_open_q <= auto_off_q;
            state_q <= auto_off_q ? cas_pkg::ST_BAL_WAIT : cas_pkg::ST_PUMP_OFF;
          end
          else
            cnt_q <= cnt_q + 22'h000001;
        cas_pkg::ST_BAL_WAIT:
          if (cnt_q == bal_target - 22'h000001)
            state_q <= cas_pkg::ST_PUMP_OFF;
          else
            cnt_q <= cnt_q + 22'h000001;
        cas_pkg::ST_PUMP_OFF:
        begin
          pump_on_q <= 1'b0;
          slot_q <= cas_pkg::SLOT_MV1;
          state_q <= cas_pkg::ST_SLOT;
        end
        cas_pkg::ST_SLOT:
          if (slot_q == cas_pkg::SLOT_END && !aux_q)
          begin
            if (last_os)
              aux_q <= 1'b1;
            else
            begin
              os_cnt_q <= os_cnt_q + 8'h01;
              cnt_q <= 22'h000000;
              pump_on_q <= 1'b1;
              state_q <= cas_pkg::ST_RECOVER;
            end
          end
          else if (slot_q == cas_pkg::SLOT_LAST)
          begin
            idx_q <= 4'h0;
            state_q <= cas_pkg::ST_XFER;
          end
          else if (slot_en)
          begin
            conv_start_q <= 1'b1;
            conv_chan_q <= chan_w;
            conv_invert_q <= slot_q >= cas_pkg::SLOT_P2 && slot_q < cas_pkg::SLOT_MV2;
            state_q <= cas_pkg::ST_WAIT;
          end
          else
            slot_q <= slot_q + 5'h01;
        cas_pkg::ST_WAIT:
          if (conv_done_in)
          begin
            slot_q <= slot_q + 5'h01;
            state_q <= cas_pkg::ST_SLOT;
          end
        cas_pkg::ST_RECOVER:
          if (cnt_q == 22'(RECOVER_CYC) - 22'h000001)
            state_q <= cas_pkg::ST_PUMP_OFF;
          else
            cnt_q <= cnt_q + 22'h000001;
        cas_pkg::ST_XFER:
          if (idx_q == cas_pkg::IDX_LAST)
          begin
            pump_on_q <= 1'b1;
            busy_q <= 1'b0;
            state_q <= cas_pkg::ST_IDLE;
          end
          else
            idx_q <= idx_q + 4'h1;
      endcase
    end

  // Result storage; a watchdog expiry wipes raw, filtered and running sums
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      for (int i = 0; i < cas_pkg::NUM_ACC; i++)
      begin
        raw_q[i] <= 16'h0000;
        cell_q[i] <= 16'h0000;
        acc_q[i] <= 24'h000000;
      end
      aux1_q <= 16'h0000;
      aux2_q <= 16'h0000;
      diag_q <= 16'h0000;
    end
    else if (tmo_hit)
    begin
      for (int i = 0; i < cas_pkg::NUM_ACC; i++)
      begin
        raw_q[i] <= 16'h0000;
        cell_q[i] <= 16'h0000;
        acc_q[i] <= 24'h000000;
      end
    end
    else
    begin
      if (start_req)
        for (int i = 0; i < cas_pkg::NUM_ACC; i++)
          acc_q[i] <= 24'h000000;
      if (acc_add)
        acc_q[conv_chan_q] <= acc_q[conv_chan_q] + 24'(conv_data_in);
      if (got_conv && conv_chan_q == cas_pkg::CH_AUX1)
        aux1_q <= conv_data_in;
      if (got_conv && conv_chan_q == cas_pkg::CH_AUX2)
        aux2_q <= conv_data_in;
      if (got_conv && conv_chan_q == cas_pkg::CH_DIAG)
        diag_q <= conv_data_in;
      if (xfer_step)
      begin
        raw_q[idx_q] <= avg_w;
        // History moves only here or on a watchdog wipe, so finished scans without filtered transfer leave it untouched
        if (fxfer_q)
          cell_q[idx_q] <= filt_w;
      end
    end

  assign reg_rdata_out = rdata_q;
  assign conv_start_out = conv_start_q;
  assign conv_chan_out = conv_chan_q;
  assign conv_invert_out = conv_invert_q;
  assign pump_on_out = pump_on_q;
  assign balance_open_out = balance_open_q;
  // Busy flop mirrors the state register so the pin comes from a flop
  assign acq_busy_out = busy_q;

  start_reads_zero_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in == cas_pkg::ADDR_ACQ_CTRL |=> !reg_rdata_out[0])
    else $error("start bit read back as one");

  done_after_xfer_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    xfer_last |=> done_q && idle)
    else $error("completion flag not set after transfer");

  hop_wait_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_q == cas_pkg::ST_HOP && cnt_q < hop_target && !tmo_hit |=> state_q == cas_pkg::ST_HOP)
    else $error("chain hop wait ended early");

  pump_off_conv_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    conv_start_q |-> !pump_on_q)
    else $error("conversion started with pump on");

  first_pass_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    conv_start_q && slot_q >= cas_pkg::SLOT_P1 && slot_q < cas_pkg::SLOT_P2
    |-> conv_chan_q == (order_q ? 4'(5'h0C - slot_q) : 4'(slot_q - 5'h01)))
    else $error("first pass channel out of order");

  second_pass_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    conv_start_q && slot_q >= cas_pkg::SLOT_P2 && slot_q < cas_pkg::SLOT_MV2
    |-> conv_chan_q == 4'(5'h18 - slot_q) && conv_invert_q)
    else $error("second pass channel out of order");

  recover_len_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_q == cas_pkg::ST_PUMP_OFF && $past(state_q) == cas_pkg::ST_RECOVER
    |-> $past(cnt_q) == 22'(RECOVER_CYC) - 22'h000001)
    else $error("recovery period wrong length");

  aux_once_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    conv_start_q && (conv_chan_q == cas_pkg::CH_AUX1 || conv_chan_q == cas_pkg::CH_AUX2)
    |-> aux_q && last_os)
    else $error("auxiliary conversion before last oversample");

  watchdog_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tmo_hit |=> tmo_q && idle && raw_q[0] == 16'h0000 && cell_q[0] == 16'h0000)
    else $error("watchdog expiry not handled");

  filter_xfer_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    xfer_step && fxfer_q |=> cell_q[$past(idx_q)] == $past(filt_w))
    else $error("filtered result not transferred");

  bal_open_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_q == cas_pkg::ST_BAL_WAIT |-> balance_open_q ##1 balance_open_q || idle)
    else $error("balancing switches not opened");

endmodule

/* File: cell_acquisition_sequencer_bench.sv */
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module cell_acquisition_sequencer_bench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic conv_start_out;
  logic conv_invert_out;
  logic conv_done_in;
  logic pump_on_out;
  logic balance_open_out;
  logic acq_busy_out;
  logic [3:0] conv_chan_out;
  logic [15:0] conv_data_in;
  logic mute = 1'b0;
  logic [6:0] exp_log [$];
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk_in = ~clk_in;
  // Short counts keep the run brief; chain position strapped to one hop
  cas_sequencer #(.HOP_CYC(2), .STEP_CYC(4), .RECOVER_CYC(4), .WD_CYC('{default: 2000}))
    cas_sequencer_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .chain_pos_in(5'h01), .conv_start_out(conv_start_out),
    .conv_chan_out(conv_chan_out), .conv_invert_out(conv_invert_out),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .pump_on_out(pump_on_out),
    .balance_open_out(balance_open_out), .acq_busy_out(acq_busy_out));
  cas_conv_model conv_model_i (.clk_in(clk_in), .conv_start_in(conv_start_out),
    .conv_chan_in(conv_chan_out), .conv_invert_in(conv_invert_out), .pump_on_in(pump_on_out),
    .balance_open_in(balance_open_out), .mute_in(mute), .conv_done_out(conv_done_in),
    .conv_data_out(conv_data_in));
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    // One idle edge keeps a following write from reassigning the strobe
    @(posedge clk_in);
  endtask
  // Read data is taken at the edge that closes the answer cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
    chk(reg_rdata_out, exp);
  endtask
  // First start lands after the hop wait, any balancing wait and pump off
  task automatic scan(input logic [15:0] ctrl, input int first_exp);
    int n;
    int first;
    conv_model_i.clear();
    wr(8'h13, ctrl);
    @(posedge clk_in);
    n = 0;
    first = 0;
    while (acq_busy_out !== 1'b0 && n < 8000)
    begin
      @(posedge clk_in);
      n++;
      if (conv_start_out === 1'b1 && first == 0)
        first = n;
    end
    chk(16'(first), 16'(first_exp));
    if (n == 8000)
    begin
      errors++;
      $display("mismatch at %0t: scan never ended", $time);
      stop_test();
    end
  endtask
  task automatic add(input logic bal, input logic inv, input logic [3:0] ch);
    exp_log.push_back({bal, 1'b0, inv, ch});
  endtask
  // One measurement cycle with cells 1 and 2, module voltage and diagnostics
  task automatic cyc(input logic bal, input logic top_down);
    add(bal, 1'b0, 4'hC);
    add(bal, 1'b0, top_down ? 4'h1 : 4'h0);
    add(bal, 1'b0, top_down ? 4'h0 : 4'h1);
    add(bal, 1'b1, 4'h1);
    add(bal, 1'b1, 4'h0);
    add(bal, 1'b0, 4'hC);
    add(bal, 1'b0, 4'hF);
    add(bal, 1'b0, 4'hF);
  endtask
  task automatic chk_log(input int recov);
    chk(16'(conv_model_i.conv_log.size()), 16'(exp_log.size()));
    foreach (exp_log[i])
      if (i < conv_model_i.conv_log.size())
        chk({9'h000, conv_model_i.conv_log[i]}, {9'h000, exp_log[i]});
    chk(16'(conv_model_i.recoveries), 16'(recov));
    exp_log.delete();
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h13, 16'h0000);
    rd(8'h10, 16'h0002);
    rd(8'h12, 16'h0FFF);
    rd(8'h0C, 16'h0000);
    rd(8'h05, 16'h0000);
    wr(8'h12, 16'hF003);
    // Pyramid order, no oversampling
    scan(16'h0001, 4);
    cyc(1'b0, 1'b0);
    add(1'b0, 1'b0, 4'hD);
    add(1'b0, 1'b0, 4'hE);
    chk_log(0);
    rd(8'h13, 16'h8000);
    // Top-down, four oversamples, auto-off with the upper delay byte, filtered transfer
    wr(8'h10, 16'h0802);
    wr(8'h0C, 16'h0100);
    scan(16'h00E7, 12);
    repeat (4) cyc(1'b1, 1'b1);
    add(1'b1, 1'b0, 4'hD);
    add(1'b1, 1'b0, 4'hE);
    chk_log(3);
    rd(8'h13, 16'h80E6);
    rd(8'h20, 16'h0018);
    rd(8'h2C, 16'h0498);
    wr(8'h13, 16'hC000);
    rd(8'h20, 16'h0040);
    rd(8'h2D, 16'h0D40);
    // Host drops auto-off, then a silent converter lets the watchdog expire
    wr(8'h10, 16'h0002);
    mute <= 1'b1;
    scan(16'h0001, 4);
    rd(8'h13, 16'h4000);
    rd(8'h20, 16'h0000);
    mute <= 1'b0;
    stop_test();
  end
endmodule
